/* File: include/spi_pkg.sv */
// Constants shared by the serial port register block and its engines.
// Assumes a 10 MHz single clock and AXI4-Lite byte addressing.
package spi_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] CTRL_IDX = 10'h0c3;
  localparam logic [9:0] STAT_IDX = 10'h0c4;
  localparam logic [9:0] DATA_IDX = 10'h0c5;
  localparam int ADDR_W = 12;
  // Control fields
  localparam int RATE_HI = 7;
  localparam int EN = 6;
  localparam int IGNORE_SEL = 5;
  localparam int MASTER = 4;
  localparam int CLOCK_POLARITY_BIT = 3;
  localparam int CLOCK_PHASE_BIT = 2;
  localparam int RATE_MID = 1;
  localparam int RATE_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h14;
  // Status fields
  localparam int DONE = 7;
  localparam int COLL = 6;
  localparam int SEL_ERR = 5;
  localparam int FAULT = 4;
  localparam logic [3:0] STAT_RSVD = 4'h0;
  // Rate code with no clock generation
  localparam logic [2:0] RATE_INVALID = 3'h7;
  // Sixteen clock edges make one byte
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    st_idle = 2'h1,
    st_shift = 2'h2
  } shift_state_e;
endpackage

/* File: design/spi_rate_divider.sv */
// Master serial clock divider: one enable pulse per half period.
// Assumes run is held for the whole byte; rate changes only while idle.
`timescale 1ns/100ps
module spi_rate_divider (
  input wire logic aclk,       // Peripheral clock
  input wire logic aresetn,    // Synchronous reset, low
  input wire logic run,        // Master byte in progress
  input wire logic [2:0] rate, // Rate select code
  output logic tick            // Half-period enable pulse
);
  typedef struct packed {
    logic [6:0] cnt;
  } div_s;
  div_s s;
  div_s next_s;
  logic [6:0] half;

  always_comb begin
    half = 7'h01 << rate;
    tick = run && (rate != spi_pkg::RATE_INVALID) && (s.cnt == half - 7'h01);
    next_s = s;
    if (!run || tick) begin
      next_s.cnt = 7'h00;
    end else begin
      next_s.cnt = s.cnt + 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

/* File: design/spi_shifter.sv */
// Byte shift engine for master and slave, all four clock formats.
// Assumes serial pins are synchronous to aclk; disabling resets it.
`timescale 1ns/100ps
module spi_shifter (
  input wire logic aclk,          // Peripheral clock
  input wire logic aresetn,       // Synchronous reset, low
  input wire logic enable,        // Port enabled
  input wire logic master,        // Master mode
  input wire logic clock_polarity_bit,          // Idle clock level
  input wire logic clock_phase_bit,          // Sample on returning edge
  input wire logic tick,          // Master half-period pulse
  input wire logic load,          // Load byte, starts a master byte
  input wire logic [7:0] tx_byte, // Byte to send
  input wire logic selected,      // Slave is selected
  input wire logic sck_in,        // Serial clock pin level
  input wire logic mosi_in,       // Master-out pin level
  input wire logic miso_in,       // Slave-out pin level
  output logic busy,              // Byte in progress
  output logic run,               // Master clock running
  output logic done,              // Byte complete pulse
  output logic [7:0] rx_byte,     // Received byte
  output logic sck_out,           // Serial clock drive
  output logic sck_oe,            // Serial clock enable
  output logic mosi_out,          // Master-out drive
  output logic mosi_oe,           // Master-out enable
  output logic miso_out,          // Slave-out drive
  output logic miso_oe            // Slave-out enable
);
  typedef struct packed {
    spi_pkg::shift_state_e st;
    logic [3:0] edges;
    logic [7:0] tx;
    logic [7:0] rx;
    logic sck_prev;
    logic sck;
    logic oe_m;
    logic oe_s;
    logic done;
  } shift_s;
  shift_s s;
  shift_s next_s;
  logic edge_seen;
  logic sample;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.sck_prev = sck_in;
    if (master) begin
      edge_seen = enable && (s.st == spi_pkg::st_shift) && tick;
    end else begin
      edge_seen = enable && selected && (sck_in != s.sck_prev);
    end
    sample = (s.edges[0] == clock_phase_bit);
    case (s.st)
      spi_pkg::st_idle: begin
        next_s.sck = clock_polarity_bit;
        if (load) begin
          next_s.tx = tx_byte;
        end
        if ((load && master) || (!master && edge_seen)) begin
          next_s.st = spi_pkg::st_shift;
        end
      end
      spi_pkg::st_shift: begin
        next_s.st = s.st;
      end
      default: begin
        next_s.st = spi_pkg::st_idle;
      end
    endcase
    if (edge_seen) begin
      if (sample) begin
        next_s.rx = {s.rx[6:0], master ? miso_in : mosi_in};
      end else if (!(clock_phase_bit && s.edges == 4'h0)) begin
        next_s.tx = {s.tx[6:0], 1'b0};
      end
      if (master) begin
        next_s.sck = ~s.sck;
      end
      next_s.edges = s.edges + 4'h1;
      if (s.edges == spi_pkg::LAST_EDGE) begin
        next_s.st = spi_pkg::st_idle;
        next_s.done = 1'b1;
      end
    end
    if (!enable || (!master && !selected)) begin
      next_s.st = spi_pkg::st_idle;
      next_s.edges = 4'h0;
      next_s.sck = clock_polarity_bit;
    end
    next_s.oe_m = enable && master;
    next_s.oe_s = enable && !master && selected;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.st <= spi_pkg::st_idle;
    end else begin
      s <= next_s;
    end
  end

  assign busy = (s.st == spi_pkg::st_shift);
  assign run = busy && master;
  assign done = s.done;
  assign rx_byte = s.rx;
  assign sck_out = s.sck;
  assign sck_oe = s.oe_m;
  assign mosi_out = s.tx[7];
  assign mosi_oe = s.oe_m;
  assign miso_out = s.tx[7];
  assign miso_oe = s.oe_s;
endmodule

/* File: design/spi_port.sv */
// Serial port control, status and error logic behind an AXI4-Lite slave.
// Assumes pins synchronous to aclk and one write and one read at a time.
//
// Overview of operation
// - Master with select honoured flags mode fault when select pin goes low.
// - Mode fault raises error request and clears enable and master bits.
// - With select ignored, the select pin never causes a mode fault.
// - Status read with mode fault set, then control write, clears it.
// - Data write during a byte in progress sets write collision.
// - Write collision raises no request; the running byte is unaffected.
// - Status access then data access clears write collision.
// - Unread further bytes are dropped; buffer keeps first byte since clear.
// - Slave select rising before byte end sets select error.
// - Select error raises no request; cleared only by disabling the port.
// - Completed byte sets transfer done, which drives the transmit request.
// - Rate code selects clock divide 2 to 128; code seven is invalid.
// - Enable bit switches the port on and off.
// - Select-ignore bit masks select pin; no effect in slave with phase zero.
// - Polarity bit sets the idle clock level.
// - Phase bit picks leaving-idle or returning-idle sampling edge.
// - Control register resets to 0x14 with documented bit layout.
// - Status holds done, collision, select error, fault in bits 7 to 4.
// - Master bit picks master or slave operation.
// - Status read with done set, then data read, clears done.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module spi_port (
  input wire logic aclk,                          // Peripheral clock, 10 MHz
  input wire logic aresetn,                       // Synchronous reset, low
  input wire logic [spi_pkg::ADDR_W-1:0] awaddr,  // Write address
  input wire logic awvalid,                       // Write address valid
  output logic awready,                           // Write address ready
  input wire logic [31:0] wdata,                  // Write data
  input wire logic [3:0] wstrb,                   // Write byte strobes
  input wire logic wvalid,                        // Write data valid
  output logic wready,                            // Write data ready
  output logic [1:0] bresp,                       // Write response
  output logic bvalid,                            // Write response valid
  input wire logic bready,                        // Write response ready
  input wire logic [spi_pkg::ADDR_W-1:0] araddr,  // Read address
  input wire logic arvalid,                       // Read address valid
  output logic arready,                           // Read address ready
  output logic [31:0] rdata,                      // Read data
  output logic [1:0] rresp,                       // Read response
  output logic rvalid,                            // Read data valid
  input wire logic rready,                        // Read data ready
  input wire logic sck_in,                        // Serial clock pin level
  output logic sck_out,                           // Serial clock drive
  output logic sck_oe,                            // Serial clock enable
  input wire logic mosi_in,                       // Master-out pin level
  output logic mosi_out,                          // Master-out drive
  output logic mosi_oe,                           // Master-out enable
  input wire logic miso_in,                       // Slave-out pin level
  output logic miso_out,                          // Slave-out drive
  output logic miso_oe,                           // Slave-out enable
  input wire logic ss_n,                          // Slave select pin, low
  output logic tx_irq,                            // Transmit request
  output logic err_irq,                           // Mode fault request
  output logic spi_irq                            // Combined request
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic done;
    logic coll;
    logic selerr;
    logic fault;
    logic [7:0] rxbuf;
    logic fault_arm;
    logic done_arm;
    logic coll_arm;
    logic aw_full;
    logic w_full;
    logic [9:0] widx;
    logic [7:0] wbyte;
    logic wlane;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic tx_irq;
    logic err_irq;
    logic spi_irq;
  } port_s;
  port_s s;
  port_s next_s;

  logic wr_do;
  logic rd_do;
  logic [9:0] ridx;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic rd_stat;
  logic rd_data;
  logic ss_ignore;
  logic selected;
  logic fault_cond;
  logic sel_lost;
  logic load;
  logic busy;
  logic run;
  logic tick;
  logic xfer_done;
  logic [7:0] rx_byte;
  logic [2:0] rate;

  assign rate = {s.ctrl[spi_pkg::RATE_HI], s.ctrl[spi_pkg::RATE_MID], s.ctrl[spi_pkg::RATE_LO]};

  spi_rate_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .rate(rate),
    .tick(tick)
  );

  spi_shifter u_shift (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(s.ctrl[spi_pkg::EN]),
    .master(s.ctrl[spi_pkg::MASTER]),
    .clock_polarity_bit(s.ctrl[spi_pkg::CLOCK_POLARITY_BIT]),
    .clock_phase_bit(s.ctrl[spi_pkg::CLOCK_PHASE_BIT]),
    .tick(tick),
    .load(load),
    .tx_byte(s.wbyte),
    .selected(selected),
    .sck_in(sck_in),
    .mosi_in(mosi_in),
    .miso_in(miso_in),
    .busy(busy),
    .run(run),
    .done(xfer_done),
    .rx_byte(rx_byte),
    .sck_out(sck_out),
    .sck_oe(sck_oe),
    .mosi_out(mosi_out),
    .mosi_oe(mosi_oe),
    .miso_out(miso_out),
    .miso_oe(miso_oe)
  );

  always_comb begin
    wr_do = s.aw_full && s.w_full && !s.bvalid;
    rd_do = arvalid && s.arready;
    ridx = araddr[spi_pkg::ADDR_W-1:2];
    wr_ctrl = wr_do && s.wlane && (s.widx == spi_pkg::CTRL_IDX);
    wr_stat = wr_do && (s.widx == spi_pkg::STAT_IDX);
    wr_data = wr_do && s.wlane && (s.widx == spi_pkg::DATA_IDX);
    rd_stat = rd_do && (ridx == spi_pkg::STAT_IDX);
    rd_data = rd_do && (ridx == spi_pkg::DATA_IDX);
    ss_ignore = s.ctrl[spi_pkg::IGNORE_SEL] && (s.ctrl[spi_pkg::MASTER] || s.ctrl[spi_pkg::CLOCK_PHASE_BIT]);
    selected = ss_ignore || !ss_n;
    fault_cond = s.ctrl[spi_pkg::EN] && s.ctrl[spi_pkg::MASTER] && !s.ctrl[spi_pkg::IGNORE_SEL] && !ss_n;
    sel_lost = s.ctrl[spi_pkg::EN] && !s.ctrl[spi_pkg::MASTER] && !ss_ignore && ss_n && busy;
    load = wr_data && !busy && s.ctrl[spi_pkg::EN];
    next_s = s;
    // Write channel: address and data held independently
    if (awvalid && s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.widx = awaddr[spi_pkg::ADDR_W-1:2];
    end
    if (wvalid && s.wready) begin
      next_s.w_full = 1'b1;
      next_s.wbyte = wdata[7:0];
      next_s.wlane = wstrb[0];
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_do) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      if ((s.widx == spi_pkg::CTRL_IDX) || (s.widx == spi_pkg::STAT_IDX) || (s.widx == spi_pkg::DATA_IDX)) begin
        next_s.bresp = spi_pkg::RESP_OKAY;
      end else begin
        next_s.bresp = spi_pkg::RESP_SLVERR;
      end
    end
    next_s.awready = !next_s.aw_full;
    next_s.wready = !next_s.w_full;
    // Read channel
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_do) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = spi_pkg::RESP_OKAY;
      case (ridx)
        spi_pkg::CTRL_IDX: next_s.rdata = {24'h000000, s.ctrl};
        spi_pkg::STAT_IDX: next_s.rdata = {24'h000000, s.done, s.coll, s.selerr, s.fault, spi_pkg::STAT_RSVD};
        spi_pkg::DATA_IDX: next_s.rdata = {24'h000000, s.rxbuf};
        default: begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = spi_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;
    // Clearing sequences first, so that a same-cycle set wins
    if (rd_stat) begin
      next_s.fault_arm = s.fault;
      next_s.done_arm = s.done;
    end
    if (rd_stat || wr_stat) begin
      next_s.coll_arm = s.coll;
    end
    if (wr_ctrl) begin
      next_s.ctrl = s.wbyte;
      if (s.fault_arm) begin
        next_s.fault = 1'b0;
        next_s.fault_arm = 1'b0;
      end
    end
    if (rd_data && s.done_arm) begin
      next_s.done = 1'b0;
      next_s.done_arm = 1'b0;
    end
    if ((rd_data || (wr_do && s.widx == spi_pkg::DATA_IDX)) && s.coll_arm) begin
      next_s.coll = 1'b0;
      next_s.coll_arm = 1'b0;
    end
    // Hardware sets
    if (wr_data && busy) begin
      next_s.coll = 1'b1;
    end
    if (!s.ctrl[spi_pkg::EN]) begin
      next_s.selerr = 1'b0;
    end
    if (sel_lost) begin
      next_s.selerr = 1'b1;
    end
    if (xfer_done) begin
      if (!s.done) begin
        next_s.rxbuf = rx_byte;
      end
      next_s.done = 1'b1;
    end
    if (fault_cond) begin
      next_s.fault = 1'b1;
      next_s.ctrl[spi_pkg::EN] = 1'b0;
      next_s.ctrl[spi_pkg::MASTER] = 1'b0;
    end
    next_s.tx_irq = next_s.done;
    next_s.err_irq = next_s.fault && !next_s.ctrl[spi_pkg::IGNORE_SEL];
    next_s.spi_irq = next_s.done || (next_s.fault && !next_s.ctrl[spi_pkg::IGNORE_SEL]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctrl <= spi_pkg::CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign tx_irq = s.tx_irq;
  assign err_irq = s.err_irq;
  assign spi_irq = s.spi_irq;

  fault_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_cond |=> s.fault && err_irq)
    else $error("mode fault not flagged");

  fault_disable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s.fault) |-> !s.ctrl[spi_pkg::EN] && !s.ctrl[spi_pkg::MASTER] ##1 !sck_oe)
    else $error("mode fault left port enabled");

  ignore_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.ctrl[spi_pkg::IGNORE_SEL] && !s.fault && !wr_ctrl) |=> !s.fault && !err_irq)
    else $error("mode fault with select ignored");

  fault_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_stat && s.fault) ##1 (!wr_ctrl && !fault_cond) [*1] ##1 (wr_ctrl && !fault_cond) |=> !s.fault)
    else $error("mode fault not cleared by sequence");

  coll_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_data && busy) |=> s.coll)
    else $error("write collision not flagged");

  coll_noirq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_data && busy && !fault_cond && !xfer_done && !sel_lost) |=> $stable(err_irq) && (busy || xfer_done))
    else $error("collision disturbed transfer");

  rxbuf_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (xfer_done && s.done) |=> $stable(s.rxbuf))
    else $error("receive buffer overwritten");

  selerr_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_lost |=> s.selerr)
    else $error("select error not flagged");

  selerr_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!s.ctrl[spi_pkg::EN] && !sel_lost) |=> !s.selerr)
    else $error("select error survives disable");

  done_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    xfer_done |=> s.done && tx_irq && spi_irq)
    else $error("transfer done not flagged");

  done_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_data && s.done_arm && !xfer_done) |=> !s.done ##1 !tx_irq || s.done)
    else $error("transfer done not cleared");

  irq_merge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    spi_irq == (tx_irq || err_irq))
    else $error("combined request mismatch");
endmodule

/* File: testbench/spi_far_slave.sv */
// Behavioural serial slave standing on the far side of the port.
// Assumes the bench selects it only around master bytes.
`timescale 1ns/100ps
module spi_far_slave (
  input wire logic aclk,      // Peripheral clock
  input wire logic sel,       // Selected by bench
  input wire logic clock_polarity_bit,      // Idle clock level
  input wire logic clock_phase_bit,      // Phase setting
  input wire logic sck,       // Serial clock line
  input wire logic mosi,      // Master-out line
  input wire logic [7:0] tx,  // Byte to return
  output logic miso,          // Slave-out drive
  output logic [7:0] rx       // Byte captured
);
  logic prev;
  logic flip;
  logic [3:0] cnt;
  logic [3:0] pos;
  initial begin
    prev = 1'b0;
    flip = 1'b0;
    cnt = 4'h0;
    rx = 8'h00;
  end
  // Released line keeps changing so a stale value cannot pass
  assign pos = clock_phase_bit ? cnt - 4'h1 : cnt;
  assign miso = sel ? tx[3'h7 - pos[2:0]] : flip;
  always @(posedge aclk) begin
    prev <= sck;
    flip <= ~flip;
    if (!sel) begin
      cnt <= 4'h0;
    end else if (prev != sck) begin
      if ((sck != clock_polarity_bit) != clock_phase_bit) begin
        rx <= {rx[6:0], mosi};
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the serial port register block.
// Assumes the far slave model and a 10 MHz clock.
`timescale 1ns/100ps
module testbench;
  localparam logic [11:0] A_CTRL = {spi_pkg::CTRL_IDX, 2'b00};
  localparam logic [11:0] A_STAT = {spi_pkg::STAT_IDX, 2'b00};
  localparam logic [11:0] A_DATA = {spi_pkg::DATA_IDX, 2'b00};
  logic aclk;
  logic aresetn;
  logic [11:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [11:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic sck_out;
  logic sck_oe;
  logic mosi_out;
  logic mosi_oe;
  logic miso_out;
  logic miso_oe;
  logic ss_n;
  logic tx_irq;
  logic err_irq;
  logic spi_irq;
  logic tb_sck;
  logic far_sel;
  logic [7:0] far_tx;
  logic [7:0] far_rx;
  logic far_miso;
  logic [7:0] cfg;
  logic sck_w;
  logic mosi_w;
  logic miso_w;
  int miscompares = 0;
  int cmp_count = 0;
  assign sck_w = sck_oe ? sck_out : tb_sck;
  assign mosi_w = mosi_oe ? mosi_out : 1'b0;
  assign miso_w = miso_oe ? miso_out : far_miso;
  spi_port spi_port_i (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w), .mosi_out, .mosi_oe,
    .miso_in(miso_w), .miso_out, .miso_oe, .ss_n, .tx_irq, .err_irq, .spi_irq
  );
  spi_far_slave spi_far_slave_i (
    .aclk, .sel(far_sel), .clock_polarity_bit(cfg[spi_pkg::CLOCK_POLARITY_BIT]), .clock_phase_bit(cfg[spi_pkg::CLOCK_PHASE_BIT]),
    .sck(sck_w), .mosi(mosi_w), .tx(far_tx), .miso(far_miso), .rx(far_rx)
  );
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      got = bvalid;
      r = bresp;
    end
  endtask
  task automatic axr(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      got = rvalid;
      d = rdata[7:0];
      r = rresp;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk(r, spi_pkg::RESP_OKAY);
  endtask
  task automatic rd_exp(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk({22'h0, r, d}, {22'h0, spi_pkg::RESP_OKAY, e});
  endtask
  // Waits for the byte to end, counting cycles with the clock away from idle
  task automatic wait_tx(input logic p, output int n);
    n = 0;
    for (int i = 0; i < 5000 && tx_irq !== 1'b1; i++) begin
      @(posedge aclk);
      if (sck_out !== p) n++;
    end
    chk(tx_irq, 1'b1);
  endtask
  task automatic t_regs();
    logic [7:0] d;
    logic [1:0] r;
    rd_exp(A_CTRL, 8'h14);
    rd_exp(A_STAT, 8'h00);
    axr(12'h000, d, r);
    chk(r, spi_pkg::RESP_SLVERR);
    axw(12'h000, 8'hff, r);
    chk(r, spi_pkg::RESP_SLVERR);
    wr(A_STAT, 8'hff);
    rd_exp(A_STAT, 8'h00);
    wr(A_CTRL, 8'h1d);
    rd_exp(A_CTRL, 8'h1d);
    chk(sck_oe, 1'b0);
    wr(A_CTRL, 8'h5d);
    @(posedge aclk);
    chk(sck_oe, 1'b1);
    chk(sck_out, 1'b1);
    wr(A_CTRL, 8'h00);
  endtask
  task automatic t_master(input logic [7:0] c, input int half, input logic [7:0] mb, input logic [7:0] sb);
    int n;
    wr(A_CTRL, 8'h00);
    cfg <= c;
    wr(A_CTRL, c);
    far_tx <= sb;
    @(posedge aclk);
    far_sel <= 1'b1;
    chk(sck_out, c[spi_pkg::CLOCK_POLARITY_BIT]);
    wr(A_DATA, mb);
    wait_tx(c[spi_pkg::CLOCK_POLARITY_BIT], n);
    chk(n, 8 * half);
    chk(spi_irq, 1'b1);
    chk(far_rx, mb);
    rd_exp(A_STAT, 8'h80);
    rd_exp(A_DATA, sb);
    rd_exp(A_STAT, 8'h00);
    far_sel <= 1'b0;
  endtask
  task automatic t_coll();
    int n;
    wr(A_CTRL, 8'h51);
    far_sel <= 1'b1;
    far_tx <= 8'h11;
    wr(A_DATA, 8'h96);
    wr(A_DATA, 8'h0f);
    rd_exp(A_STAT, 8'h40);
    wait_tx(1'b0, n);
    chk(err_irq, 1'b0);
    chk(far_rx, 8'h96);
    far_sel <= 1'b0;
    @(posedge aclk);
    far_sel <= 1'b1;
    far_tx <= 8'h22;
    wr(A_DATA, 8'h5a);
    for (int i = 0; i < 500 && far_rx !== 8'h5a; i++) @(posedge aclk);
    repeat (8) @(posedge aclk);
    rd_exp(A_STAT, 8'h80);
    rd_exp(A_DATA, 8'h11);
    rd_exp(A_STAT, 8'h00);
    far_sel <= 1'b0;
  endtask
  task automatic t_mode_fault_flag();
    wr(A_CTRL, 8'h51);
    ss_n <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(err_irq, 1'b1);
    chk(spi_irq, 1'b1);
    ss_n <= 1'b1;
    rd_exp(A_STAT, 8'h10);
    rd_exp(A_CTRL, 8'h01);
    wr(A_CTRL, 8'h51);
    rd_exp(A_STAT, 8'h00);
    chk(err_irq, 1'b0);
    wr(A_CTRL, 8'h71);
    ss_n <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(err_irq, 1'b0);
    rd_exp(A_STAT, 8'h00);
    ss_n <= 1'b1;
    wr(A_CTRL, 8'h00);
  endtask
  task automatic t_select_error_flag();
    wr(A_CTRL, 8'h40);
    ss_n <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(miso_oe, 1'b1);
    chk(sck_oe, 1'b0);
    repeat (4) begin
      tb_sck <= ~tb_sck;
      repeat (3) @(posedge aclk);
    end
    ss_n <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({tx_irq, err_irq}, 2'b00);
    rd_exp(A_STAT, 8'h20);
    wr(A_CTRL, 8'h00);
    rd_exp(A_STAT, 8'h00);
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    end_of_test();
  end
  initial begin
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
    wstrb = 4'hf;
    bready = 1'b1;
    rready = 1'b1;
    ss_n = 1'b1;
    tb_sck = 1'b0;
    far_sel = 1'b0;
    far_tx = 8'h00;
    cfg = 8'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    $display("registers done");
    t_coll();
    $display("collision done");
    t_master(8'h51, 2, 8'ha5, 8'h3c);
    t_master(8'h5e, 4, 8'h69, 8'hc3);
    t_master(8'h5b, 8, 8'h0f, 8'hf0);
    t_master(8'hd0, 16, 8'h81, 8'h7e);
    t_master(8'hd1, 32, 8'h33, 8'hcc);
    t_master(8'hd6, 64, 8'h5a, 8'h18);
    $display("master done");
    t_mode_fault_flag();
    $display("mode fault done");
    t_select_error_flag();
    $display("select error done");
    end_of_test();
  end
endmodule
